// ### common/two_wire_params.svh
// offsets, field positions, reset values, status codes and timing counts
// assumes inclusion by bare name from the design files
`ifndef TWO_WIRE_PARAMS_SVH
`define TWO_WIRE_PARAMS_SVH

`define TW_OFF_OWN          8'h00
`define TW_OFF_CTRL         8'h04
`define TW_OFF_STAT         8'h08
`define TW_OFF_DATA         8'h0C

`define TW_CTRL_FLAG        7
`define TW_CTRL_ACK         6
`define TW_CTRL_STA         5
`define TW_CTRL_STO         4
`define TW_CTRL_WCOL        3
`define TW_CTRL_EN          2
`define TW_CTRL_IE          0
`define TW_STAT_CODE_LSB    3

`define TW_RST_OWN          8'h00
`define TW_RST_DATA         8'hFF
`define TW_ST_IDLE          8'hF8
`define TW_ST_START         8'h08
`define TW_ST_OWN_W         8'h60
`define TW_ST_ARB_OWN_W     8'h68
`define TW_ST_GC            8'h70
`define TW_ST_ARB_GC        8'h78
`define TW_ST_DATA_ACK      8'h80
`define TW_ST_DATA_NACK     8'h88
`define TW_ST_GC_ACK        8'h90
`define TW_ST_GC_NACK       8'h98
`define TW_ST_STOP          8'hA0

`define TW_CLK_NS           5
`define TW_START_HOLD_NS    4000
`define TW_START_HOLD_CYC   ((`TW_START_HOLD_NS + `TW_CLK_NS - 1) / `TW_CLK_NS)

`endif

// ### common/two_wire_pkg.sv
// types shared by the two-wire slave receiver
// assumes nothing beyond a SystemVerilog compiler
package two_wire_pkg;

    typedef enum logic [3:0] {
        st_idle        = 4'b0000,
        st_addr        = 4'b0001,
        st_addr_ack    = 4'b0011,
        st_data        = 4'b0010,
        st_data_ack    = 4'b0110,
        st_stretch     = 4'b0111,
        st_gen_start   = 4'b0101,
        st_mst_hold    = 4'b0100,
        st_mst_release = 4'b1100
    } fsm_type;

    typedef struct packed {
        logic scl;
        logic sda;
    } pins_in_type;

    typedef struct packed {
        logic scl_out;
        logic scl_oe;
        logic sda_out;
        logic sda_oe;
    } pins_out_type;

    typedef struct packed {
        fsm_type      fsm;
        logic [7:0]   own_addr;
        logic         ack_en;
        logic         start_req;
        logic         stop_req;
        logic         wcol;
        logic         en;
        logic         ie;
        logic         flag;
        logic [4:0]   status;
        logic [1:0]   presc;
        logic [7:0]   data;
        logic [7:0]   shift;
        logic [3:0]   cnt;
        logic         gc;
        logic         arb;
        logic         nack;
        logic         sda_drv;
        logic         scl_drv;
        logic         busy;
        logic         sleep_match;
        logic [15:0]  tcnt;
        logic [31:0]  rdata;
        logic         scl_s1;
        logic         scl_s2;
        logic         scl_d;
        logic         sda_s1;
        logic         sda_s2;
        logic         sda_d;
    } state_type;

endpackage : two_wire_pkg

// ### core/two_wire_slave_receiver.sv
// two-wire slave receiver with apb register access
// assumes pins resolved open-drain outside; line inputs are asynchronous
`include "two_wire_params.svh"

module two_wire_slave_receiver #(
    parameter int ADDR_WIDTH     = 12,
    parameter int START_HOLD_CYC = `TW_START_HOLD_CYC
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [ADDR_WIDTH-1:0]      paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire two_wire_pkg::pins_in_type  line_in,
    output two_wire_pkg::pins_out_type      line_out,
    input  wire logic                       deep_sleep,
    output logic                            wake_request
);

    ////////////////////////////////////////////////////////////////////////////
    generate
        if (ADDR_WIDTH < 4 || START_HOLD_CYC < 1 || START_HOLD_CYC > 65535) begin : g_bad_param
            $error("two_wire_slave_receiver: unsupported parameter value");
        end
    endgenerate

    localparam logic [1:0] IDX_OWN  = 2'(`TW_OFF_OWN >> 2);
    localparam logic [1:0] IDX_CTRL = 2'(`TW_OFF_CTRL >> 2);
    localparam logic [1:0] IDX_STAT = 2'(`TW_OFF_STAT >> 2);
    localparam logic [1:0] IDX_DATA = 2'(`TW_OFF_DATA >> 2);
    localparam logic [15:0] HOLD_LAST = 16'(START_HOLD_CYC - 1);

    two_wire_pkg::state_type st_reg;
    two_wire_pkg::state_type st_next;

    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic access_hit;

    // only the four word slots at the bottom decode
    function automatic logic reg_hit(input logic [ADDR_WIDTH-1:0] a);
        reg_hit = (a[ADDR_WIDTH-1:4] == '0) && (a[1:0] == 2'b00);
    endfunction : reg_hit

    function automatic logic [4:0] code5(input logic [7:0] c);
        code5 = c[7:`TW_STAT_CODE_LSB];
    endfunction : code5

    // third stage only feeds edge detection, never the first stage
    assign scl_rise   = st_reg.scl_s2 && !st_reg.scl_d;
    assign scl_fall   = !st_reg.scl_s2 && st_reg.scl_d;
    assign start_cond = st_reg.scl_s2 && st_reg.scl_d && st_reg.sda_d && !st_reg.sda_s2;
    assign stop_cond  = st_reg.scl_s2 && st_reg.scl_d && !st_reg.sda_d && st_reg.sda_s2;
    assign access_hit = reg_hit(paddr);

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic       set_flag;
        logic       clr_flag;
        logic [7:0] code;
        logic       own_hit;
        logic       gc_hit;
        set_flag = 1'b0;
        clr_flag = 1'b0;
        code     = `TW_ST_IDLE;
        own_hit  = 1'b0;
        gc_hit   = 1'b0;
        st_next  = st_reg;

        st_next.scl_s1 = line_in.scl;
        st_next.scl_s2 = st_reg.scl_s1;
        st_next.scl_d  = st_reg.scl_s2;
        st_next.sda_s1 = line_in.sda;
        st_next.sda_s2 = st_reg.sda_s1;
        st_next.sda_d  = st_reg.sda_s2;

        // read data fetched in setup so it is a flop in access
        if (psel && !penable && !pwrite) begin
            st_next.rdata = 32'h0000_0000;
            if (access_hit) begin
                unique case (paddr[3:2])
                    IDX_OWN:  st_next.rdata[7:0] = st_reg.own_addr;
                    IDX_CTRL: st_next.rdata[7:0] = {st_reg.flag, st_reg.ack_en, st_reg.start_req,
                                                    st_reg.stop_req, st_reg.wcol, st_reg.en,
                                                    1'b0, st_reg.ie};
                    IDX_STAT: st_next.rdata[7:0] = {st_reg.status, 1'b0, st_reg.presc};
                    IDX_DATA: st_next.rdata[7:0] = st_reg.data;
                endcase
            end
        end

        if (psel && penable && pwrite && access_hit) begin
            unique case (paddr[3:2])
                IDX_OWN:  st_next.own_addr = pwdata[7:0];
                IDX_CTRL: begin
                    st_next.ack_en    = pwdata[`TW_CTRL_ACK];
                    st_next.start_req = pwdata[`TW_CTRL_STA];
                    st_next.stop_req  = pwdata[`TW_CTRL_STO];
                    st_next.en        = pwdata[`TW_CTRL_EN];
                    st_next.ie        = pwdata[`TW_CTRL_IE];
                    clr_flag          = pwdata[`TW_CTRL_FLAG];
                end
                IDX_STAT: st_next.presc = pwdata[1:0];
                IDX_DATA: begin
                    if (st_reg.flag) begin
                        st_next.data = pwdata[7:0];
                        st_next.wcol = 1'b0;
                    end else begin
                        st_next.wcol = 1'b1;
                    end
                end
            endcase
        end

        if (start_cond) begin
            st_next.busy = 1'b1;
        end else if (stop_cond) begin
            st_next.busy = 1'b0;
        end

        ////////////////////////////////////////////////////////////////////////
        if (!st_reg.en) begin
            st_next.fsm     = two_wire_pkg::st_idle;
            st_next.sda_drv = 1'b0;
            st_next.scl_drv = 1'b0;
        end else if (st_reg.stop_req && st_reg.fsm != two_wire_pkg::st_mst_hold) begin
            // stop request in slave mode only recovers to not addressed
            st_next.stop_req = 1'b0;
            st_next.fsm      = two_wire_pkg::st_idle;
            st_next.sda_drv  = 1'b0;
            st_next.scl_drv  = 1'b0;
        end else if ((start_cond || stop_cond) && st_reg.fsm == two_wire_pkg::st_data) begin
            set_flag    = 1'b1;
            code        = `TW_ST_STOP;
            st_next.fsm = two_wire_pkg::st_idle;
        end else begin
            unique case (st_reg.fsm)
                two_wire_pkg::st_idle: begin
                    // monitoring never stops, even with ack_en low
                    if (start_cond) begin
                        st_next.fsm = two_wire_pkg::st_addr;
                        st_next.cnt = 4'h0;
                    end else if (st_reg.start_req && !st_reg.busy && !st_reg.flag) begin
                        st_next.fsm  = two_wire_pkg::st_gen_start;
                        st_next.tcnt = 16'h0000;
                    end
                end
                two_wire_pkg::st_addr: begin
                    if (stop_cond) begin
                        st_next.fsm = two_wire_pkg::st_idle;
                    end else if (start_cond) begin
                        st_next.cnt = 4'h0;
                    end else if (scl_rise) begin
                        st_next.shift = {st_reg.shift[6:0], st_reg.sda_s2};
                        st_next.cnt   = 4'(st_reg.cnt + 4'h1);
                    end else if (scl_fall && st_reg.cnt == 4'h8) begin
                        own_hit = st_reg.shift[7:1] == st_reg.own_addr[7:1];
                        gc_hit  = st_reg.shift[7:1] == 7'h00 && st_reg.own_addr[0];
                        // read direction is left to the transmitter, not here
                        if (st_reg.ack_en && !st_reg.shift[0] && (own_hit || gc_hit)) begin
                            st_next.sda_drv     = 1'b1;
                            st_next.gc          = gc_hit;
                            st_next.arb         = st_reg.start_req;
                            st_next.sleep_match = deep_sleep;
                            st_next.fsm         = two_wire_pkg::st_addr_ack;
                        end else begin
                            st_next.fsm = two_wire_pkg::st_idle;
                        end
                    end
                end
                two_wire_pkg::st_addr_ack: begin
                    if (scl_fall) begin
                        st_next.sda_drv = 1'b0;
                        st_next.scl_drv = 1'b1;
                        st_next.nack    = 1'b0;
                        st_next.fsm     = two_wire_pkg::st_stretch;
                        set_flag        = 1'b1;
                        if (st_reg.gc) begin
                            code = st_reg.arb ? `TW_ST_ARB_GC : `TW_ST_GC;
                        end else begin
                            code = st_reg.arb ? `TW_ST_ARB_OWN_W : `TW_ST_OWN_W;
                        end
                    end
                end
                two_wire_pkg::st_stretch: begin
                    // a slow wake-up keeps the line low for as long as it takes
                    st_next.scl_drv = 1'b1;
                    if (!st_reg.flag) begin
                        st_next.scl_drv     = 1'b0;
                        st_next.sleep_match = 1'b0;
                        st_next.cnt         = 4'h0;
                        st_next.fsm = st_reg.nack ? two_wire_pkg::st_idle : two_wire_pkg::st_data;
                    end
                end
                two_wire_pkg::st_data: begin
                    if (scl_rise) begin
                        st_next.shift = {st_reg.shift[6:0], st_reg.sda_s2};
                        st_next.cnt   = 4'(st_reg.cnt + 4'h1);
                    end else if (scl_fall && st_reg.cnt == 4'h8) begin
                        st_next.sda_drv = st_reg.ack_en;
                        st_next.nack    = !st_reg.ack_en;
                        if (!deep_sleep) begin
                            st_next.data = st_reg.shift;
                        end
                        st_next.fsm = two_wire_pkg::st_data_ack;
                    end
                end
                two_wire_pkg::st_data_ack: begin
                    if (scl_fall) begin
                        st_next.sda_drv = 1'b0;
                        st_next.scl_drv = 1'b1;
                        st_next.fsm     = two_wire_pkg::st_stretch;
                        set_flag        = 1'b1;
                        if (st_reg.gc) begin
                            code = st_reg.nack ? `TW_ST_GC_NACK : `TW_ST_GC_ACK;
                        end else begin
                            code = st_reg.nack ? `TW_ST_DATA_NACK : `TW_ST_DATA_ACK;
                        end
                    end
                end
                two_wire_pkg::st_gen_start: begin
                    st_next.sda_drv = 1'b1;
                    st_next.tcnt    = 16'(st_reg.tcnt + 16'h0001);
                    if (st_reg.tcnt == HOLD_LAST) begin
                        st_next.scl_drv   = 1'b1;
                        st_next.start_req = 1'b0;
                        st_next.fsm       = two_wire_pkg::st_mst_hold;
                        set_flag          = 1'b1;
                        code              = `TW_ST_START;
                    end
                end
                two_wire_pkg::st_mst_hold: begin
                    // master transfers are not served: the bus is handed back with a stop
                    if (!st_reg.flag) begin
                        st_next.scl_drv = 1'b0;
                        st_next.tcnt    = 16'h0000;
                        st_next.fsm     = two_wire_pkg::st_mst_release;
                    end
                end
                two_wire_pkg::st_mst_release: begin
                    st_next.tcnt = 16'(st_reg.tcnt + 16'h0001);
                    if (st_reg.tcnt == HOLD_LAST) begin
                        st_next.sda_drv  = 1'b0;
                        st_next.stop_req = 1'b0;
                        st_next.fsm      = two_wire_pkg::st_idle;
                    end
                end
                default: begin
                    st_next.fsm     = two_wire_pkg::st_idle;
                    st_next.sda_drv = 1'b0;
                    st_next.scl_drv = 1'b0;
                end
            endcase
        end

        // hardware set wins over a software clear in the same cycle
        if (set_flag) begin
            st_next.flag   = 1'b1;
            st_next.status = code5(code);
        end else if (clr_flag) begin
            st_next.flag   = 1'b0;
            st_next.status = code5(`TW_ST_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg          <= '0;
            st_reg.own_addr <= `TW_RST_OWN;
            st_reg.data     <= `TW_RST_DATA;
            st_reg.status   <= code5(`TW_ST_IDLE);
            st_reg.scl_s1   <= 1'b1;
            st_reg.scl_s2   <= 1'b1;
            st_reg.scl_d    <= 1'b1;
            st_reg.sda_s1   <= 1'b1;
            st_reg.sda_s2   <= 1'b1;
            st_reg.sda_d    <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata           = st_reg.rdata;
    assign pready           = 1'b1;
    assign pslverr          = psel && penable && !access_hit;
    assign line_out.scl_out = 1'b0;
    assign line_out.scl_oe  = st_reg.scl_drv;
    assign line_out.sda_out = 1'b0;
    assign line_out.sda_oe  = st_reg.sda_drv;
    assign wake_request     = st_reg.sleep_match;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic byte_end;
    assign byte_end = scl_fall && st_reg.cnt == 4'h8 && st_reg.en && !st_reg.stop_req;

    a_addr_status: assert property ((st_reg.fsm == two_wire_pkg::st_addr_ack && scl_fall && st_reg.en
                                     && !st_reg.stop_req) |=> st_reg.flag && st_reg.scl_drv
                                     && (st_reg.status == code5(`TW_ST_OWN_W) || st_reg.status == code5(`TW_ST_GC)
                                     || st_reg.status == code5(`TW_ST_ARB_OWN_W)
                                     || st_reg.status == code5(`TW_ST_ARB_GC)))
        else $error("address ack did not raise flag with address status");
    a_gc_ignored: assert property ((st_reg.fsm == two_wire_pkg::st_addr && byte_end && !start_cond
                                    && st_reg.shift[7:1] == 7'h00 && !st_reg.own_addr[0]
                                    && st_reg.own_addr[7:1] != 7'h00)
                                   |=> st_reg.fsm == two_wire_pkg::st_idle && !line_out.sda_oe)
        else $error("general call answered while disabled");
    a_ack_gated: assert property ((st_reg.fsm == two_wire_pkg::st_addr && byte_end && !start_cond
                                   && !st_reg.ack_en) |=> !line_out.sda_oe [*2])
        else $error("address acknowledged with ack_en low");
    a_read_ignored: assert property ((st_reg.fsm == two_wire_pkg::st_addr && byte_end && !start_cond
                                      && st_reg.shift[0]) |=> st_reg.fsm == two_wire_pkg::st_idle)
        else $error("read direction entered receive");
    a_data_nack: assert property ((st_reg.fsm == two_wire_pkg::st_data && byte_end && !start_cond
                                   && !stop_cond && !st_reg.ack_en) |=> !line_out.sda_oe ##1 st_reg.nack)
        else $error("byte acknowledged with ack_en low");
    a_data_ack: assert property ((st_reg.fsm == two_wire_pkg::st_data && byte_end && !start_cond
                                  && !stop_cond && st_reg.ack_en && !deep_sleep) |=> line_out.sda_oe
                                  && st_reg.data == $past(st_reg.shift))
        else $error("byte not acknowledged or not stored");
    a_sleep_data: assert property ((st_reg.fsm == two_wire_pkg::st_data && byte_end && !start_cond
                                    && !stop_cond && deep_sleep) |=> st_reg.data == $past(st_reg.data)
                                    && line_out.sda_oe == $past(st_reg.ack_en))
        else $error("byte stored while asleep");
    a_stretch_hold: assert property ((st_reg.fsm == two_wire_pkg::st_stretch && st_reg.flag
                                      && st_reg.en && !st_reg.stop_req) |=> line_out.scl_oe)
        else $error("clock released while flag set");
    a_stop_report: assert property ((st_reg.fsm == two_wire_pkg::st_data && stop_cond && st_reg.en
                                     && !st_reg.stop_req) |=> st_reg.flag
                                     && st_reg.status == code5(`TW_ST_STOP)
                                     && st_reg.fsm == two_wire_pkg::st_idle)
        else $error("stop while addressed not reported");
    a_nack_release: assert property ((st_reg.fsm == two_wire_pkg::st_stretch && !st_reg.flag
                                      && st_reg.nack && st_reg.en && !st_reg.stop_req)
                                     |=> st_reg.fsm == two_wire_pkg::st_idle && !line_out.scl_oe)
        else $error("not-acknowledged transfer stayed addressed");
    a_wake_hold: assert property (wake_request && st_reg.fsm == two_wire_pkg::st_stretch && st_reg.flag
                                  |-> line_out.scl_oe)
        else $error("clock released during wake-up");
    a_start_gen: assert property ($rose(st_reg.fsm == two_wire_pkg::st_gen_start)
                                  |=> line_out.sda_oe && !line_out.scl_oe)
        else $error("start not driven");

    c_own_write: cover property (st_reg.flag && st_reg.status == code5(`TW_ST_OWN_W));
    c_data_ack:  cover property (st_reg.flag && st_reg.status == code5(`TW_ST_DATA_ACK));
    c_gc_nack:   cover property (st_reg.flag && st_reg.status == code5(`TW_ST_GC_NACK));
    c_stop:      cover property (st_reg.flag && st_reg.status == code5(`TW_ST_STOP));

endmodule : two_wire_slave_receiver

// ### bench/tw_master.sv
// two-wire bus master model writing bytes to the slave receiver
// assumes open-drain lines resolved with pull-ups in the bench
module tw_master (
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_low,
    output logic      sda_low
);
    timeunit 1ns;
    timeprecision 1ps;
    int stalls = 0;
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    // bounded: a slave that never lets go ends the wait
    task automatic wait_high;
        for (int n = 0; n < 4000 && scl !== 1'b1; n++) #5;
        if (scl !== 1'b1) stalls++;
    endtask : wait_high
    task automatic pulse(output logic smp);
        #12 scl_low = 1'b0;
        wait_high();
        smp = sda;
        #24 scl_low = 1'b1;
    endtask : pulse
    task automatic start_c;
        sda_low = 1'b1;
        #24 scl_low = 1'b1;
    endtask : start_c
    task automatic stop_c;
        #12 sda_low = 1'b1;
        #12 scl_low = 1'b0;
        wait_high();
        #24 sda_low = 1'b0;
        #24;
    endtask : stop_c
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            #12 sda_low = ~b[i];
            pulse(s);
        end
        #12 sda_low = 1'b0;
        pulse(s);
        ack = ~s;
        #24;
    endtask : put_byte
endmodule : tw_master

// ### bench/two_wire_slave_receiver_tb.sv
// bench for the two-wire slave receiver: apb tasks, master model, checks
// assumes pull-ups on both lines, resolved here from every open-drain driver
module two_wire_slave_receiver_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, deep_sleep = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, r;
    logic        pready, pslverr, wake_request, scl, sda, msl, mda, k, err;
    logic [6:0]  a;
    logic [7:0]  d;
    logic        hung = 1'b0;
    int          miscompares = 0, num_checks = 0;
    two_wire_pkg::pins_out_type lo;
    always #2.5 pclk = ~pclk;
    assign scl = ~(msl | lo.scl_oe);
    assign sda = ~(mda | lo.sda_oe);
    two_wire_slave_receiver #(.START_HOLD_CYC(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .line_in({scl, sda}), .line_out(lo), .deep_sleep(deep_sleep),
        .wake_request(wake_request));
    tw_master m (.scl(scl), .sda(sda), .scl_low(msl), .sda_low(mda));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        r = prdata;
        err = pslverr;
        if (n == 20) hung = 1'b1;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic xfer(input logic [7:0] b, input logic ae, input logic [7:0] code);
        m.put_byte(b, k);
        chk("ack", {31'h0, k}, {31'h0, ae});
        if (code != 8'h00) begin
            chk("stretch", {31'h0, lo.scl_oe}, 32'h0000_0001);
            apb(1'b0, 12'h008, 32'h0000_0000);
            chk("status", r & 32'h0000_00f8, {24'h0, code});
            apb(1'b0, 12'h004, 32'h0000_0000);
            chk("flag", r & 32'h0000_0080, 32'h0000_0080);
        end
    endtask : xfer
    task automatic end_sim;
        if (miscompares == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim
    ////////////////////////////////////////////////////////////////////////////
    task automatic run;
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk("slverr", {31'h0, err}, 32'h0000_0001);
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk("status_rst", r, 32'h0000_00f8);
        a = 7'($urandom_range(127, 1));
        apb(1'b1, 12'h000, {24'h0, a, 1'b1});
        apb(1'b1, 12'h004, 32'h0000_0044);
        m.start_c();
        xfer({a, 1'b0}, 1'b1, 8'h60);
        repeat (2) begin
            d = 8'($urandom);
            apb(1'b1, 12'h004, 32'h0000_00c4);
            xfer(d, 1'b1, 8'h80);
            apb(1'b0, 12'h00c, 32'h0000_0000);
            chk("data", r, {24'h0, d});
        end
        apb(1'b1, 12'h004, 32'h0000_0084);
        xfer(8'($urandom), 1'b0, 8'h88);
        apb(1'b1, 12'h004, 32'h0000_00c4);
        m.stop_c();
        m.start_c();
        xfer(8'h00, 1'b1, 8'h70);
        d = 8'($urandom);
        apb(1'b1, 12'h004, 32'h0000_00c4);
        xfer(d, 1'b1, 8'h90);
        apb(1'b1, 12'h004, 32'h0000_00c4);
        m.stop_c();
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk("stop_status", r & 32'h0000_00f8, 32'h0000_00a0);
        // refusals: wrong address, read bit, general call off, ack off
        for (int i = 0; i < 4; i++) begin
            // general call off in even cases: a flipped address of zero must stay unanswered
            apb(1'b1, 12'h000, {24'h0, a, i[0]});
            apb(1'b1, 12'h004, (i == 3) ? 32'h0000_0004 : 32'h0000_00c4);
            m.start_c();
            xfer((i == 0) ? {a ^ 7'h01, 1'b0} : (i == 1) ? {a, 1'b1} : (i == 2) ? 8'h00 : {a, 1'b0}, 1'b0, 8'h00);
            m.stop_c();
        end
        apb(1'b1, 12'h004, 32'h0000_0044);
        deep_sleep <= 1'b1;
        m.start_c();
        xfer({a, 1'b0}, 1'b1, 8'h60);
        chk("wake", {31'h0, wake_request}, 32'h0000_0001);
        apb(1'b1, 12'h004, 32'h0000_00c4);
        repeat (2) @(posedge pclk);
        chk("wake_end", {31'h0, wake_request}, 32'h0000_0000);
        xfer(8'($urandom), 1'b1, 8'h80);
        apb(1'b0, 12'h00c, 32'h0000_0000);
        chk("data_sleep", r, {24'h0, d});
        deep_sleep <= 1'b0;
        apb(1'b1, 12'h004, 32'h0000_00c4);
        m.stop_c();
        // start request pending while addressed, then a start once the bus is free
        m.start_c();
        apb(1'b1, 12'h004, 32'h0000_00e4);
        xfer({a, 1'b0}, 1'b1, 8'h68);
        apb(1'b1, 12'h004, 32'h0000_00e4);
        m.stop_c();
        apb(1'b1, 12'h004, 32'h0000_00e4);
        repeat (8) @(posedge pclk);
        chk("start_sda", {31'h0, sda}, 32'h0000_0000);
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk("start_status", r & 32'h0000_00f8, 32'h0000_0008);
        apb(1'b1, 12'h004, 32'h0000_00c4);
        repeat (12) @(posedge pclk);
        chk("released", {30'h0, scl, sda}, 32'h0000_0003);
    endtask : run
    initial begin
        void'($urandom(32'h2aae));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        fork
            run();
            begin
                for (int c = 0; c < 90000 && !hung && m.stalls == 0; c++) @(posedge pclk);
                miscompares++;
            end
        join_any
        end_sim();
    end
endmodule : two_wire_slave_receiver_tb
